// ---- hdl/mct_pkg.sv ----
/*
 * Shared constants, register map and types of the multi-channel timer.
 * Assumes a 32-bit AHB-Lite register bus and one timer clock.
 */
package mct_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int DATA_W     = 32;
	localparam int CNT_W      = 32;
	localparam int PSC_W      = 16;
	localparam int NCH        = 4;
	localparam int DT_W       = 8;
	localparam int OFF_W      = 8;
	localparam int CHM_W      = 4;
	localparam int EV_W       = 6;
	localparam int CTRL_W     = 10;
	localparam int WORD_BYTES = 4;
	localparam int HTRANS_ACT = 1;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [OFF_W-1:0] OFF_CTRL   = 8'h00;
	localparam logic [OFF_W-1:0] OFF_PSC    = 8'h04;
	localparam logic [OFF_W-1:0] OFF_RELOAD = 8'h08;
	localparam logic [OFF_W-1:0] OFF_COUNT  = 8'h0C;
	localparam logic [OFF_W-1:0] OFF_CHMODE = 8'h10;
	localparam logic [OFF_W-1:0] OFF_CMP0   = 8'h14;
	localparam logic [OFF_W-1:0] OFF_DEAD   = 8'h24;
	localparam logic [OFF_W-1:0] OFF_STATUS = 8'h28;
	localparam logic [OFF_W-1:0] OFF_MASK   = 8'h2C;
	localparam logic [OFF_W-1:0] OFF_DMAEN  = 8'h30;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_EN       = 0;
	localparam int CTRL_DOWN     = 1;
	localparam int CTRL_CENTER   = 2;
	localparam int CTRL_ONEPULSE = 3;
	localparam int CTRL_NARROW   = 4;
	localparam int CTRL_FREEZE   = 5;
	localparam int CTRL_SLV_LSB  = 6;
	localparam int CTRL_SLV_MSB  = 7;
	localparam int CTRL_HALL     = 8;
	localparam int CTRL_COMPL    = 9;
	localparam int CHM_MODE_LSB  = 0;
	localparam int CHM_MODE_MSB  = 1;
	localparam int CHM_OE        = 2;
	localparam int CHM_POL       = 3;
	localparam int EV_UPDATE     = 0;
	localparam int EV_CC0        = 1;
	localparam int EV_TRIG       = 5;

	// ----------------------------------------------------------------
	// Reset values and constants
	// ----------------------------------------------------------------
	localparam logic [CTRL_W-1:0]     CTRL_RST    = 10'h000;
	localparam logic [PSC_W-1:0]      PSC_RST     = 16'h0000;
	localparam logic [CNT_W-1:0]      RELOAD_RST  = 32'hFFFF_FFFF;
	localparam logic [CNT_W-1:0]      WIDE_MASK   = 32'hFFFF_FFFF;
	localparam logic [CNT_W-1:0]      NARROW_MASK = 32'h0000_FFFF;
	localparam logic [CNT_W-1:0]      CNT_ZERO    = 32'h0000_0000;
	localparam logic [CNT_W-1:0]      CNT_ONE     = 32'h0000_0001;
	localparam logic [NCH*CHM_W-1:0]  CHMODE_RST  = 16'h0000;
	localparam logic [DT_W-1:0]       DEAD_RST    = 8'h00;
	localparam logic [DT_W-1:0]       DEAD_ONE    = 8'h01;
	localparam logic [EV_W-1:0]       EV_RST      = 6'h00;
	localparam logic [DATA_W-1:0]     RD_ZERO     = 32'h0000_0000;
	localparam logic                  HRESP_OKAY  = 1'b0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CHM_CAPTURE = 2'b00,
		CHM_TOGGLE  = 2'b01,
		CHM_PWM     = 2'b11,
		CHM_ONMATCH = 2'b10
	} mct_chmode_type;

	typedef enum logic [1:0] {
		SLV_FREE    = 2'b00,
		SLV_ENCODER = 2'b01,
		SLV_TRIGGER = 2'b11,
		SLV_RESET   = 2'b10
	} mct_slave_type;

	typedef enum logic {
		DIR_UP   = 1'b0,
		DIR_DOWN = 1'b1
	} mct_dir_type;

	// Byte offset of compare word idx
	function automatic logic [OFF_W-1:0] cmp_off(input int idx);
		return OFF_CMP0 + OFF_W'(idx * WORD_BYTES);
	endfunction : cmp_off

	// Quadrature step: {moved, downward}; forward order 00-01-11-10
	function automatic logic [1:0] quad_step(input logic [1:0] prev, input logic [1:0] cur);
		return {^(prev ^ cur), cur != {prev[0], ~prev[1]}};
	endfunction : quad_step

endpackage : mct_pkg

// ---- hdl/mct_prescaler.sv ----
/*
 * Clock prescaler of the timer: one tick every div+1 enabled cycles.
 * Assumes div is stable while running; a clear restarts the division.
 */
`timescale 1ns/100ps
module mct_prescaler (
	input  wire logic                     hclk,
	input  wire logic                     hresetn,
	input  wire logic                     ce,
	input  wire logic                     run,
	input  wire logic                     clear,
	input  wire logic [mct_pkg::PSC_W-1:0] div,
	output logic                          tick
);

	logic [mct_pkg::PSC_W-1:0] cnt_reg;
	logic [mct_pkg::PSC_W-1:0] cnt_next;

	always_comb begin
		tick     = run && !clear && (cnt_reg >= div);
		cnt_next = cnt_reg;
		if (clear) begin
			cnt_next = mct_pkg::PSC_RST;
		end else if (tick) begin
			cnt_next = mct_pkg::PSC_RST;
		end else if (run) begin
			cnt_next = cnt_reg + mct_pkg::PSC_W'(1);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_reg <= mct_pkg::PSC_RST;
		end else if (ce) begin
			cnt_reg <= cnt_next;
		end
	end

endmodule : mct_prescaler

// ---- hdl/mct_channel.sv ----
/*
 * One capture/compare channel: capture edge detect, compare, PWM,
 * single-pulse reference and a complementary pair with dead time.
 * Assumes count and cmp come from the timer core of the same clock.
 */
`timescale 1ns/100ps
module mct_channel (
	input  wire logic                     hclk,
	input  wire logic                     hresetn,
	input  wire logic                     ce,
	input  wire logic                     active,
	input  wire logic [mct_pkg::CNT_W-1:0] count,
	input  wire logic [mct_pkg::CNT_W-1:0] cmp,
	input  wire logic                     counted,
	input  wire logic                     upd,
	input  wire logic [mct_pkg::CHM_W-1:0] mode,
	input  wire logic                     compl_en,
	input  wire logic [mct_pkg::DT_W-1:0]  dead,
	input  wire logic                     cap_in,
	output logic                          out,
	output logic                          out_n,
	output logic                          cap_ev,
	output logic                          match_ev
);

	mct_pkg::mct_chmode_type   sel;
	logic                      ref_reg;
	logic                      ref_next;
	logic                      seen_reg;
	logic                      seen_next;
	logic [mct_pkg::DT_W-1:0]  dt_reg;
	logic [mct_pkg::DT_W-1:0]  dt_next;
	logic                      cap_prev_reg;
	logic                      out_next;
	logic                      out_n_next;
	logic                      settled;
	logic                      pol;
	logic                      oe;

	always_comb begin
		sel       = mct_pkg::mct_chmode_type'(mode[mct_pkg::CHM_MODE_MSB:mct_pkg::CHM_MODE_LSB]);
		pol       = mode[mct_pkg::CHM_POL];
		oe        = mode[mct_pkg::CHM_OE] && active;
		match_ev  = active && counted && (count == cmp) && (sel != mct_pkg::CHM_CAPTURE);
		cap_ev    = active && (sel == mct_pkg::CHM_CAPTURE) && cap_in && !cap_prev_reg;
		ref_next  = ref_reg;
		case (sel)
			mct_pkg::CHM_CAPTURE: ref_next = 1'b0;
			mct_pkg::CHM_TOGGLE:  ref_next = match_ev ? !ref_reg : ref_reg;
			// cmp 0 never on, cmp above reload always on
			mct_pkg::CHM_PWM:     ref_next = count < cmp;
			mct_pkg::CHM_ONMATCH: ref_next = match_ev ? 1'b1 : (upd ? 1'b0 : ref_reg);
			default:              ref_next = 1'b0;
		endcase
		// Both sides off for dead+1 cycles after every change of the reference
		seen_next = ref_reg;
		dt_next   = dt_reg;
		if (ref_reg != seen_reg) begin
			dt_next = dead;
		end else if (dt_reg != mct_pkg::DEAD_RST) begin
			dt_next = dt_reg - mct_pkg::DEAD_ONE;
		end
		settled    = (ref_reg == seen_reg) && (dt_reg == mct_pkg::DEAD_RST);
		out_next   = 1'b0;
		out_n_next = 1'b0;
		if (oe) begin
			if (compl_en) begin
				out_next   = (seen_reg && settled) ^ pol;
				out_n_next = (!seen_reg && settled) ^ pol;
			end else begin
				out_next   = ref_reg ^ pol;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ref_reg      <= 1'b0;
			seen_reg     <= 1'b0;
			dt_reg       <= mct_pkg::DEAD_RST;
			cap_prev_reg <= 1'b0;
			out          <= 1'b0;
			out_n        <= 1'b0;
		end else if (ce) begin
			ref_reg      <= ref_next;
			seen_reg     <= seen_next;
			dt_reg       <= dt_next;
			cap_prev_reg <= cap_in;
			out          <= out_next;
			out_n        <= out_n_next;
		end
	end

endmodule : mct_channel

// ---- hdl/mct_timer.sv ----
/*
 * Auto-reload timer/counter with four capture/compare channels,
 * encoder and Hall inputs, DMA requests, interrupt and timer link.
 * Assumes an AHB-Lite master with word accesses and pins synchronous
 * to hclk. Variants are chosen by the CH_USED and UP_ONLY parameters.
 */
`timescale 1ns/100ps

// Function
// - Wide variant: 32-bit auto-reload up/down counter behind 16-bit prescaler.
// - Narrow variant: same counter limited to 16 bits.
// - Prescaler divides the clock by any factor from 1 to 65536.
// - Four channels: capture, compare, PWM or single pulse each.
// - PWM edge-aligned or center-aligned, selected per timer.
// - Complementary mode drives four output pairs, eight outputs.
// - Programmable dead time between the two outputs of a pair.
// - PWM duty reaches every value from fully off to fully on.
// - Counter freezes while the processor is halted, if freezing is selected.
// - Timer events can start, reset or chain other timers.
// - Quadrature encoder decode and three Hall sensor inputs.
// - Each timer raises its own independent DMA requests.
// - Reduced variants count up only except in encoder mode, 16-bit, usable as time base.
// - Reduced variants have one or two channels, synchronizable.
// - Basic timers: no channels, up only, DAC trigger or time base.
module mct_timer #(
	parameter int   CH_USED = 4,
	parameter logic UP_ONLY = 1'b0
) (
	input  wire logic                          hclk,
	input  wire logic                          hresetn,
	input  wire logic                          ce,
	input  wire logic                          hsel,
	input  wire logic [31:0]                   haddr,
	input  wire logic [1:0]                    htrans,
	input  wire logic                          hwrite,
	input  wire logic [2:0]                    hsize,
	input  wire logic [mct_pkg::DATA_W-1:0]    hwdata,
	input  wire logic                          hready,
	output logic      [mct_pkg::DATA_W-1:0]    hrdata,
	output logic                               hreadyout,
	output logic                               hresp,
	input  wire logic                          dbg_halt,
	input  wire logic                          trig_in,
	input  wire logic [mct_pkg::NCH-1:0]       ch_in,
	output logic      [mct_pkg::NCH-1:0]       ch_out,
	output logic      [mct_pkg::NCH-1:0]       ch_out_n,
	output logic                               irq,
	output logic      [mct_pkg::EV_W-1:0]      dma_req,
	output logic                               trig_out
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [mct_pkg::CTRL_W-1:0]       ctrl_reg,    ctrl_next;
	logic [mct_pkg::PSC_W-1:0]        psc_reg,     psc_next;
	logic [mct_pkg::CNT_W-1:0]        reload_reg,  reload_next;
	logic [mct_pkg::CNT_W-1:0]        count_reg,   count_next;
	logic [mct_pkg::NCH*mct_pkg::CHM_W-1:0] chmode_reg, chmode_next;
	logic [mct_pkg::CNT_W-1:0]        cmp_reg      [mct_pkg::NCH];
	logic [mct_pkg::CNT_W-1:0]        cmp_next     [mct_pkg::NCH];
	logic [mct_pkg::DT_W-1:0]         dead_reg,    dead_next;
	logic [mct_pkg::EV_W-1:0]         status_reg,  status_next;
	logic [mct_pkg::EV_W-1:0]         mask_reg,    mask_next;
	logic [mct_pkg::EV_W-1:0]         dmaen_reg,   dmaen_next;
	mct_pkg::mct_dir_type             dir_reg,     dir_next;
	logic [1:0]                       enc_prev_reg;
	logic [2:0]                       hall_prev_reg;
	logic                             wr_reg,      wr_next;
	logic                             rd_reg,      rd_next;
	logic [mct_pkg::OFF_W-1:0]        addr_reg,    addr_next;
	logic [mct_pkg::DATA_W-1:0]       hrdata_next;
	logic                             hreadyout_next;
	logic                             irq_next;
	logic [mct_pkg::EV_W-1:0]         dma_next;

	// ----------------------------------------------------------------
	// Working signals
	// ----------------------------------------------------------------
	mct_pkg::mct_slave_type           slave;
	logic                             take;
	logic [mct_pkg::DATA_W-1:0]       rd_val;
	logic [mct_pkg::CNT_W-1:0]        cmask;
	logic [mct_pkg::CNT_W-1:0]        top;
	logic                             run;
	logic                             tick;
	logic                             advance;
	logic                             upd;
	logic                             center;
	logic                             go_down;
	logic [1:0]                       enc;
	logic                             hall_chg;
	logic [mct_pkg::NCH-1:0]          cap_ev;
	logic [mct_pkg::NCH-1:0]          match_ev;
	logic [mct_pkg::NCH-1:0]          cap_fire;
	logic [mct_pkg::EV_W-1:0]         ev;
	logic [mct_pkg::EV_W-1:0]         clr;

	// ----------------------------------------------------------------
	// Bus slave: writes take no wait, reads one wait state
	// ----------------------------------------------------------------
	always_comb begin
		take           = hsel && hready && htrans[mct_pkg::HTRANS_ACT];
		wr_next        = take && hwrite;
		rd_next        = take && !hwrite;
		addr_next      = take ? haddr[mct_pkg::OFF_W-1:0] : addr_reg;
		// Wait state lets a read see a write finished one edge earlier
		hreadyout_next = !rd_next;
		rd_val         = mct_pkg::RD_ZERO;
		case (addr_reg)
			mct_pkg::OFF_CTRL:   rd_val[mct_pkg::CTRL_W-1:0] = ctrl_reg;
			mct_pkg::OFF_PSC:    rd_val[mct_pkg::PSC_W-1:0]  = psc_reg;
			mct_pkg::OFF_RELOAD: rd_val = reload_reg;
			mct_pkg::OFF_COUNT:  rd_val = count_reg;
			mct_pkg::OFF_CHMODE: rd_val[mct_pkg::NCH*mct_pkg::CHM_W-1:0] = chmode_reg;
			mct_pkg::OFF_DEAD:   rd_val[mct_pkg::DT_W-1:0]   = dead_reg;
			mct_pkg::OFF_STATUS: rd_val[mct_pkg::EV_W-1:0]   = status_reg;
			mct_pkg::OFF_MASK:   rd_val[mct_pkg::EV_W-1:0]   = mask_reg;
			mct_pkg::OFF_DMAEN:  rd_val[mct_pkg::EV_W-1:0]   = dmaen_reg;
			default:             rd_val = mct_pkg::RD_ZERO;
		endcase
		for (int i = 0; i < mct_pkg::NCH; i++) begin
			if (addr_reg == mct_pkg::cmp_off(i)) begin
				rd_val = cmp_reg[i];
			end
		end
		hrdata_next = rd_reg ? rd_val : hrdata;
	end

	// ----------------------------------------------------------------
	// Counter core
	// ----------------------------------------------------------------
	always_comb begin
		slave    = mct_pkg::mct_slave_type'(ctrl_reg[mct_pkg::CTRL_SLV_MSB:mct_pkg::CTRL_SLV_LSB]);
		cmask    = (ctrl_reg[mct_pkg::CTRL_NARROW] || UP_ONLY) ?
			mct_pkg::NARROW_MASK : mct_pkg::WIDE_MASK;
		top      = reload_reg & cmask;
		run      = ctrl_reg[mct_pkg::CTRL_EN]
			&& !(ctrl_reg[mct_pkg::CTRL_FREEZE] && dbg_halt);
		enc      = mct_pkg::quad_step(enc_prev_reg, ch_in[1:0]);
		advance  = (slave == mct_pkg::SLV_ENCODER) ? (run && enc[1]) : tick;
		center   = ctrl_reg[mct_pkg::CTRL_CENTER] && !UP_ONLY
			&& (slave != mct_pkg::SLV_ENCODER);
		go_down  = (slave == mct_pkg::SLV_ENCODER) ? enc[0]
			: (ctrl_reg[mct_pkg::CTRL_DOWN] && !UP_ONLY);
		upd        = 1'b0;
		dir_next   = dir_reg;
		count_next = count_reg;
		if (wr_reg && addr_reg == mct_pkg::OFF_COUNT) begin
			count_next = hwdata & cmask;
		end else if (slave == mct_pkg::SLV_RESET && trig_in) begin
			count_next = mct_pkg::CNT_ZERO;
		end else if (advance) begin
			if (center) begin
				// Update at both turning points of the triangle
				if (dir_reg == mct_pkg::DIR_UP) begin
					if (count_reg >= top) begin
						count_next = (count_reg - mct_pkg::CNT_ONE) & cmask;
						dir_next   = mct_pkg::DIR_DOWN;
						upd        = 1'b1;
					end else begin
						count_next = (count_reg + mct_pkg::CNT_ONE) & cmask;
					end
				end else begin
					if (count_reg == mct_pkg::CNT_ZERO) begin
						count_next = mct_pkg::CNT_ONE & cmask;
						dir_next   = mct_pkg::DIR_UP;
						upd        = 1'b1;
					end else begin
						count_next = (count_reg - mct_pkg::CNT_ONE) & cmask;
					end
				end
			end else if (go_down) begin
				if (count_reg == mct_pkg::CNT_ZERO) begin
					count_next = top;
					upd        = 1'b1;
				end else begin
					count_next = (count_reg - mct_pkg::CNT_ONE) & cmask;
				end
			end else begin
				if (count_reg >= top) begin
					count_next = mct_pkg::CNT_ZERO;
					upd        = 1'b1;
				end else begin
					count_next = (count_reg + mct_pkg::CNT_ONE) & cmask;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Register writes, events and interrupt
	// ----------------------------------------------------------------
	always_comb begin
		ctrl_next   = ctrl_reg;
		psc_next    = psc_reg;
		reload_next = reload_reg;
		chmode_next = chmode_reg;
		dead_next   = dead_reg;
		mask_next   = mask_reg;
		dmaen_next  = dmaen_reg;
		clr         = mct_pkg::EV_RST;
		for (int i = 0; i < mct_pkg::NCH; i++) begin
			cmp_next[i] = cmp_reg[i];
		end
		if (wr_reg) begin
			case (addr_reg)
				mct_pkg::OFF_CTRL:   ctrl_next   = hwdata[mct_pkg::CTRL_W-1:0];
				mct_pkg::OFF_PSC:    psc_next    = hwdata[mct_pkg::PSC_W-1:0];
				mct_pkg::OFF_RELOAD: reload_next = hwdata;
				mct_pkg::OFF_CHMODE: chmode_next = hwdata[mct_pkg::NCH*mct_pkg::CHM_W-1:0];
				mct_pkg::OFF_DEAD:   dead_next   = hwdata[mct_pkg::DT_W-1:0];
				mct_pkg::OFF_STATUS: clr         = hwdata[mct_pkg::EV_W-1:0];
				mct_pkg::OFF_MASK:   mask_next   = hwdata[mct_pkg::EV_W-1:0];
				mct_pkg::OFF_DMAEN:  dmaen_next  = hwdata[mct_pkg::EV_W-1:0];
				default:             clr         = mct_pkg::EV_RST;
			endcase
			for (int i = 0; i < mct_pkg::NCH; i++) begin
				if (addr_reg == mct_pkg::cmp_off(i)) begin
					cmp_next[i] = hwdata;
				end
			end
		end
		if (slave == mct_pkg::SLV_TRIGGER && trig_in) begin
			ctrl_next[mct_pkg::CTRL_EN] = 1'b1;
		end
		if (upd && ctrl_reg[mct_pkg::CTRL_ONEPULSE]) begin
			ctrl_next[mct_pkg::CTRL_EN] = 1'b0;
		end
		// Hall mode: any sensor change captures the count on channel 0
		hall_chg = ctrl_reg[mct_pkg::CTRL_HALL] && (ch_in[2:0] != hall_prev_reg);
		cap_fire = cap_ev;
		if (ctrl_reg[mct_pkg::CTRL_HALL]) begin
			cap_fire[0] = hall_chg;
		end
		for (int i = 0; i < mct_pkg::NCH; i++) begin
			if (cap_fire[i]) begin
				cmp_next[i] = count_reg;
			end
		end
		ev = mct_pkg::EV_RST;
		ev[mct_pkg::EV_UPDATE] = upd;
		ev[mct_pkg::EV_CC0 +: mct_pkg::NCH] = cap_fire | match_ev;
		ev[mct_pkg::EV_TRIG] = trig_in || hall_chg;
		// A new event beats a clear in the same cycle
		status_next = (status_reg & ~clr) | ev;
		irq_next    = |(status_next & mask_reg);
		dma_next    = ev & dmaen_reg;
	end

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------
	mct_prescaler u_psc (
		.hclk    (hclk),
		.hresetn (hresetn),
		.ce      (ce),
		.run     (run && slave != mct_pkg::SLV_ENCODER),
		.clear   (wr_reg && (addr_reg == mct_pkg::OFF_PSC || addr_reg == mct_pkg::OFF_COUNT)),
		.div     (psc_reg),
		.tick    (tick)
	);

	for (genvar g = 0; g < mct_pkg::NCH; g++) begin : g_ch
		mct_channel u_ch (
			.hclk     (hclk),
			.hresetn  (hresetn),
			.ce       (ce),
			.active   (g < CH_USED),
			.count    (count_reg),
			.cmp      (cmp_reg[g]),
			.counted  (advance),
			.upd      (upd),
			.mode     (chmode_reg[g*mct_pkg::CHM_W +: mct_pkg::CHM_W]),
			.compl_en (ctrl_reg[mct_pkg::CTRL_COMPL]),
			.dead     (dead_reg),
			.cap_in   (ch_in[g]),
			.out      (ch_out[g]),
			.out_n    (ch_out_n[g]),
			.cap_ev   (cap_ev[g]),
			.match_ev (match_ev[g])
		);
	end

	// ----------------------------------------------------------------
	// State registers
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_reg      <= mct_pkg::CTRL_RST;
			psc_reg       <= mct_pkg::PSC_RST;
			reload_reg    <= mct_pkg::RELOAD_RST;
			count_reg     <= mct_pkg::CNT_ZERO;
			chmode_reg    <= mct_pkg::CHMODE_RST;
			dead_reg      <= mct_pkg::DEAD_RST;
			status_reg    <= mct_pkg::EV_RST;
			mask_reg      <= mct_pkg::EV_RST;
			dmaen_reg     <= mct_pkg::EV_RST;
			dir_reg       <= mct_pkg::DIR_UP;
			enc_prev_reg  <= 2'b00;
			hall_prev_reg <= 3'b000;
			wr_reg        <= 1'b0;
			rd_reg        <= 1'b0;
			addr_reg      <= mct_pkg::OFF_CTRL;
			hrdata        <= mct_pkg::RD_ZERO;
			hreadyout     <= 1'b1;
			hresp         <= mct_pkg::HRESP_OKAY;
			irq           <= 1'b0;
			dma_req       <= mct_pkg::EV_RST;
			trig_out      <= 1'b0;
			for (int i = 0; i < mct_pkg::NCH; i++) begin
				cmp_reg[i] <= mct_pkg::CNT_ZERO;
			end
		end else if (ce) begin
			ctrl_reg      <= ctrl_next;
			psc_reg       <= psc_next;
			reload_reg    <= reload_next;
			count_reg     <= count_next;
			chmode_reg    <= chmode_next;
			dead_reg      <= dead_next;
			status_reg    <= status_next;
			mask_reg      <= mask_next;
			dmaen_reg     <= dmaen_next;
			dir_reg       <= dir_next;
			enc_prev_reg  <= ch_in[1:0];
			hall_prev_reg <= ch_in[2:0];
			wr_reg        <= wr_next;
			rd_reg        <= rd_next;
			addr_reg      <= addr_next;
			hrdata        <= hrdata_next;
			hreadyout     <= hreadyout_next;
			hresp         <= mct_pkg::HRESP_OKAY;
			irq           <= irq_next;
			dma_req       <= dma_next;
			trig_out      <= upd;
			for (int i = 0; i < mct_pkg::NCH; i++) begin
				cmp_reg[i] <= cmp_next[i];
			end
		end
	end

endmodule : mct_timer

// ---- tb/mct_timer_asserts.sv ----
/* Bus timing and output freeze checks of the timer.
 * Assumes a bind onto mct_timer with hready fed from hreadyout. */
`timescale 1ns/100ps
module mct_timer_asserts (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        ce,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [5:0]  dma_req,
	input wire logic        trig_out
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic rd_tk;
	logic wr_tk;
	assign rd_tk = hsel && hready && htrans[1] && ce && !hwrite;
	assign wr_tk = hsel && hready && htrans[1] && ce && hwrite;
	property p_okay; hresp == 1'b0; endproperty
	a_okay: assert property (p_okay) else $error("bad hresp");
	property p_rd_wait; rd_tk |=> !hreadyout; endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("no read wait");
	property p_rd_one; !hreadyout && ce |=> hreadyout; endproperty
	a_rd_one: assert property (p_rd_one) else $error("long wait");
	property p_wr; wr_tk |=> hreadyout; endproperty
	a_wr: assert property (p_wr) else $error("write waited");
	property p_cause; $fell(hreadyout) |-> $past(rd_tk); endproperty
	a_cause: assert property (p_cause) else $error("stray wait");
	property p_hold; hreadyout && $past(hreadyout) |-> $stable(hrdata); endproperty
	a_hold: assert property (p_hold) else $error("hrdata moved");
	property p_stall; !ce |=> $stable({dma_req, trig_out, hreadyout, hrdata}); endproperty
	a_stall: assert property (p_stall) else $error("moved while stalled");
	property p_dma; dma_req[0] |-> trig_out; endproperty
	a_dma: assert property (p_dma) else $error("dma without update");
endmodule : mct_timer_asserts

// ---- tb/mct_load_model.sv ----
/* Quadrature encoder on the capture pins of the timer.
 * Assumes step pulses synchronous to hclk. */
`timescale 1ns/100ps
module mct_load_model (
	input  wire logic       hclk,
	input  wire logic       step,
	input  wire logic       back,
	output logic      [3:0] ch_in
);
	logic [1:0] ph_reg = 2'h0;
	always_ff @(posedge hclk) begin
		if (step) ph_reg <= back ? ph_reg - 2'h1 : ph_reg + 2'h1;
	end
	// Gray order, so one line moves per step
	assign ch_in = {2'h0, ph_reg[1], ^ph_reg};
endmodule : mct_load_model

// ---- tb/mct_timer_test.sv ----
/* Self-checking bench of mct_timer with an encoder model.
 * Assumes the timer is the only AHB-Lite slave. */
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
	$display("ERROR %0t %h %h", $time, a, e); end end
module mct_timer_test;
	logic        hclk, hresetn, ce, hsel, hwrite, dbg_halt, trig_in, step, back, irq;
	logic        hreadyout, hresp, trig_out;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, d;
	logic [3:0]  ch_in, ch_out, ch_out_n;
	logic [5:0]  dma_req;
	int          fail_count, num_checks, n;
	initial begin
		{hclk, hresetn, ce, hsel, hwrite, dbg_halt, trig_in, step, back} = '0;
		{htrans, haddr, hwdata} = '0;
		forever #2 hclk = ~hclk;
	end
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : conclude
	// Bounded: a hung bus ends the run
	task automatic wrdy;
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
			if (k > 99) begin fail_count++; conclude; end
		end while (hreadyout !== 1'b1);
	endtask : wrdy
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
		{hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 24'h0, a};
		wrdy;
		{htrans, hwdata} <= {2'h0, v};
		wrdy;
		d = hrdata;
	endtask : bus
	task automatic cnt(input logic h);
		n = 0;
		do begin
			dbg_halt <= h && n < 5;
			@(posedge hclk);
			n++;
		end while (trig_out !== 1'b1 && n < 200);
		if (n >= 200) begin fail_count++; conclude; end
	endtask : cnt
	task automatic t_reset;
		bus(0, mct_pkg::OFF_RELOAD, 0);
		`CHK(d, 32'hFFFF_FFFF)
		bus(1, 8'h40, 32'h1234_5678);
		bus(0, 8'h40, 0);
		`CHK(d, 32'h0000_0000)
		`CHK({irq, dma_req, trig_out, ch_out}, 12'h000)
		$display("t_reset done");
	endtask : t_reset
	// Up, down, narrow with debug freeze, center-aligned; 3 clocks per count
	task automatic t_period;
		logic [9:0]  c [4] = '{10'h001, 10'h003, 10'h031, 10'h005};
		logic [31:0] r [4] = '{32'h0000_0003, 32'h0000_0003, 32'h0001_0003, 32'h0000_0003};
		for (int i = 0; i < 4; i++) begin
			bus(1, mct_pkg::OFF_CTRL, 0);
			bus(1, mct_pkg::OFF_PSC, 2);
			bus(1, mct_pkg::OFF_RELOAD, r[i]);
			bus(1, mct_pkg::OFF_CTRL, {22'h0, c[i]});
			cnt(0);
			cnt(c[i][5]);
			`CHK(n, c[i][5] ? 17 : c[i][2] ? 9 : 12)
		end
		$display("t_period done");
	endtask : t_period
	task automatic t_irq;
		bus(1, mct_pkg::OFF_DMAEN, 1);
		bus(1, mct_pkg::OFF_MASK, 1);
		cnt(0);
		`CHK(dma_req, 6'h01)
		bus(0, mct_pkg::OFF_STATUS, 0);
		`CHK({irq, d[0]}, 2'h3)
		bus(1, mct_pkg::OFF_MASK, 0);
		bus(1, mct_pkg::OFF_CTRL, 0);
		`CHK(irq, 1'b0)
		bus(1, mct_pkg::OFF_STATUS, 32'h0000_003F);
		bus(1, mct_pkg::OFF_MASK, 1);
		bus(0, mct_pkg::OFF_STATUS, 0);
		`CHK({irq, d[5:0]}, 7'h00)
		$display("t_irq done");
	endtask : t_irq
	task automatic t_pwm;
		logic [31:0] cm [3] = '{32'h0000_0000, 32'h0000_0005, 32'h0000_000A};
		int ex [3] = '{20, 12, 40};
		bus(1, mct_pkg::OFF_PSC, 0);
		bus(1, mct_pkg::OFF_RELOAD, 9);
		bus(1, mct_pkg::OFF_DEAD, 2);
		bus(1, mct_pkg::OFF_CHMODE, 32'h0000_0007);
		bus(1, mct_pkg::OFF_CTRL, 10'h201);
		for (int i = 0; i < 3; i++) begin
			bus(1, mct_pkg::OFF_CMP0, cm[i]);
			ce <= 0;
			repeat (4) @(posedge hclk);
			ce <= 1;
			repeat (12) @(posedge hclk);
			n = 0;
			repeat (20) begin @(posedge hclk); n += 2 * ch_out[0] + ch_out_n[0]; end
			`CHK(n, ex[i])
		end
		$display("t_pwm done");
	endtask : t_pwm
	task automatic t_enc;
		bus(1, mct_pkg::OFF_CTRL, 32'h0000_0041);
		bus(1, mct_pkg::OFF_COUNT, 0);
		for (int i = 0; i < 7; i++) begin
			{step, back} <= {1'b1, i > 4};
			@(posedge hclk);
			step <= 0;
			repeat (4) @(posedge hclk);
		end
		bus(0, mct_pkg::OFF_COUNT, 0);
		`CHK(d, 32'h0000_0003)
		bus(1, mct_pkg::OFF_CTRL, 8'h80);
		trig_in <= 1;
		bus(0, mct_pkg::OFF_COUNT, 0);
		`CHK(d, 32'h0)
		$display("t_enc done");
	endtask : t_enc
	initial begin
		repeat (20) @(posedge hclk);
		{hresetn, ce} <= 2'h3;
		t_reset;
		t_period;
		t_irq;
		t_pwm;
		t_enc;
		conclude;
	end
	mct_timer mct_timer_i (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.dbg_halt, .trig_in, .ch_in, .ch_out, .ch_out_n, .irq, .dma_req, .trig_out);
	mct_load_model mct_load_model_i (.hclk, .step, .back, .ch_in);
endmodule : mct_timer_test
bind mct_timer mct_timer_asserts mct_timer_asserts_i (.hclk, .hresetn, .ce, .hsel,
	.htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .dma_req, .trig_out);
